// *** hw/sfc_port.sv ***
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "sfc_map.svh"
module sfc_port
#(
   parameter int PAGE_BYTES     = 256,
   parameter int NUM_SECTORS    = 32,
   parameter bit PERMIT_PRESENT = 1'b1
)
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        sid_req_in,
   input  wire logic        status_req_in,
   input  wire logic        erase_req_in,
   input  wire logic        protect_req_in,
   input  wire logic        write_req_in,
   input  wire logic        shift_bytes_in,
   input  wire logic        write_permit_in,
   input  wire logic [23:0] addr_in,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  silicon_ident_out,
   output logic      [7:0]  status_byte_out,
   output logic             busy_out,
   output logic             illegal_erase_out,
   output logic             illegal_write_out,
   output logic             flash_sclk_out,
   output logic             flash_cs_n_out,
   output logic             flash_mosi_out,
   input  wire logic        flash_miso_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             irq_out
);

   localparam int AW = $clog2(PAGE_BYTES);

   if (PAGE_BYTES < 2 || PAGE_BYTES > 256 || (1 << AW) != PAGE_BYTES)
   begin : g_bad_page
      $error("PAGE_BYTES must be a power of two from 2 to 256");
   end
   if (NUM_SECTORS < 1 || NUM_SECTORS > 256)
   begin : g_bad_sect
      $error("NUM_SECTORS must lie from 1 to 256");
   end

   sfc_pkg::sfc_state_t state_reg;
   sfc_pkg::sfc_state_t state_next;
   sfc_pkg::sfc_op_t    op_reg;
   sfc_pkg::sfc_op_t    op_next;
   sfc_pkg::sfc_op_t    op_take;
   sfc_pkg::sfc_fr_t    fr_reg;
   sfc_pkg::sfc_fr_t    fr_next;
   sfc_pkg::sfc_fr_t    fr_first;
   logic [8:0]          idx_reg;
   logic [8:0]          idx_next;
   logic [8:0]          pcnt_reg;
   logic [23:0]         addr_reg;
   logic [7:0]          data_reg;
   logic [1:0]          ill_e_reg;
   logic [1:0]          ill_w_reg;
   logic [3:0]          irq_stat_reg;
   logic [3:0]          irq_mask_reg;
   logic                eng_done;
   logic [7:0]          eng_rx;
   logic [7:0]          buf_rdata;
   logic                in_frame_reg;

   // Byte sent at a given position of a flash frame
   function automatic logic [7:0] fr_byte(input sfc_pkg::sfc_fr_t fr,
                                          input logic [8:0]       i,
                                          input logic [23:0]      a,
                                          input logic [7:0]       d,
                                          input logic [7:0]       pb,
                                          input logic             pg);
      logic [7:0] ab;
      ab = (i == 9'h001) ? a[23:16] : (i == 9'h002) ? a[15:8] : a[7:0];
      case (fr)
         sfc_pkg::FR_SID:  fr_byte = (i == 9'h000) ? `SFC_OPC_SID : 8'h00;
         sfc_pkg::FR_WREN: fr_byte = `SFC_OPC_WREN;
         sfc_pkg::FR_SE:   fr_byte = (i == 9'h000) ? `SFC_OPC_SE : ab;
         sfc_pkg::FR_WRSR: fr_byte = (i == 9'h000) ? `SFC_OPC_WRSR : d;
         sfc_pkg::FR_PP:
         begin
            if (i == 9'h000)
               fr_byte = `SFC_OPC_PP;
            else if (i < `SFC_HDR_LEN)
               fr_byte = ab;
            else
               fr_byte = pg ? pb : d;
         end
         default:          fr_byte = (i == 9'h000) ? `SFC_OPC_RDSR : 8'h00;
      endcase
   endfunction : fr_byte

   // Number of bytes in a flash frame
   function automatic logic [8:0] fr_len(input sfc_pkg::sfc_fr_t fr,
                                         input logic [8:0]       pc);
      case (fr)
         sfc_pkg::FR_SID:  fr_len = `SFC_LEN_SID;
         sfc_pkg::FR_WREN: fr_len = `SFC_LEN_WREN;
         sfc_pkg::FR_SE:   fr_len = `SFC_LEN_SE;
         sfc_pkg::FR_WRSR: fr_len = `SFC_LEN_WRSR;
         sfc_pkg::FR_PP:   fr_len = `SFC_HDR_LEN + ((pc == 9'h000) ? 9'h001 : pc);
         default:          fr_len = `SFC_LEN_RDSR;
      endcase
   endfunction : fr_len

   // Block protect bits guard the top 2^(bp-1) sectors
   function automatic logic prot_hit(input logic [7:0] sr, input logic [23:0] a);
      logic [2:0] bp;
      logic [9:0] span;
      bp   = sr[`SFC_SR_BP_LSB +: 3];
      span = (bp == 3'h0) ? 10'h000 : (10'h001 << (bp - 3'h1));
      prot_hit = (bp != 3'h0) &&
                 (({2'b00, a[`SFC_SECTOR_LSB +: 8]} + span) >= 10'(NUM_SECTORS));
   endfunction : prot_hit

   // Command acceptance
   wire idle       = (state_reg == sfc_pkg::S_IDLE);
   wire permit     = !PERMIT_PRESENT || write_permit_in;
   wire rd_req     = sid_req_in | status_req_in;
   wire wr_req     = erase_req_in | protect_req_in | write_req_in;
   wire take_rd    = idle & rd_req;
   wire take_wr    = idle & !rd_req & wr_req & permit;
   wire refuse     = idle & !rd_req & wr_req & !permit;
   wire accept     = take_rd | take_wr;
   wire page_mode  = (pcnt_reg != 9'h000);
   wire buf_wr     = shift_bytes_in & idle & (pcnt_reg < 9'(PAGE_BYTES));
   wire [8:0] boff = idx_reg - `SFC_HDR_LEN;
   wire eng_start  = (state_reg == sfc_pkg::S_SEND);
   wire [7:0] tx   = fr_byte(fr_reg, idx_reg, addr_reg, data_reg, buf_rdata, page_mode);
   wire fin        = (state_reg == sfc_pkg::S_GAP) && (state_next == sfc_pkg::S_IDLE);
   wire to_abort   = (state_reg == sfc_pkg::S_GAP) && (state_next == sfc_pkg::S_ABORT);
   wire abort_e    = to_abort && (op_reg == sfc_pkg::OP_ERASE);
   wire abort_w    = to_abort && (op_reg == sfc_pkg::OP_WRITE);
   wire in_frame   = (state_next == sfc_pkg::S_LOAD) || (state_next == sfc_pkg::S_SEND) ||
                     (state_next == sfc_pkg::S_WAIT);

   assign op_take  = sid_req_in     ? sfc_pkg::OP_SID   :
                     status_req_in  ? sfc_pkg::OP_RDSR  :
                     erase_req_in   ? sfc_pkg::OP_ERASE :
                     protect_req_in ? sfc_pkg::OP_PROT  : sfc_pkg::OP_WRITE;

   // Erase and write read the protection bits first
   assign fr_first = (op_take == sfc_pkg::OP_SID)  ? sfc_pkg::FR_SID  :
                     (op_take == sfc_pkg::OP_PROT) ? sfc_pkg::FR_WREN : sfc_pkg::FR_RDSR;

   assign busy_out          = !idle;
   assign illegal_erase_out = ill_e_reg[0];
   assign illegal_write_out = ill_w_reg[0];
   assign flash_cs_n_out    = !in_frame_reg;

   // Frame sequencer
   always_comb
   begin
      state_next = state_reg;
      op_next    = op_reg;
      fr_next    = fr_reg;
      idx_next   = idx_reg;
      case (state_reg)
         sfc_pkg::S_IDLE:
         begin
            if (accept)
            begin
               op_next    = op_take;
               fr_next    = fr_first;
               idx_next   = 9'h000;
               state_next = sfc_pkg::S_LOAD;
            end
         end
         sfc_pkg::S_LOAD:
            state_next = sfc_pkg::S_SEND;
         sfc_pkg::S_SEND:
            state_next = sfc_pkg::S_WAIT;
         sfc_pkg::S_WAIT:
         begin
            if (eng_done)
            begin
               if ((idx_reg + 9'h001) < fr_len(fr_reg, pcnt_reg))
               begin
                  idx_next   = idx_reg + 9'h001;
                  state_next = sfc_pkg::S_LOAD;
               end
               else
                  state_next = sfc_pkg::S_GAP;
            end
         end
         sfc_pkg::S_GAP:
         begin
            idx_next   = 9'h000;
            state_next = sfc_pkg::S_LOAD;
            case (fr_reg)
               sfc_pkg::FR_SID:
                  state_next = sfc_pkg::S_IDLE;
               sfc_pkg::FR_RDSR:
               begin
                  if (op_reg == sfc_pkg::OP_RDSR)
                     state_next = sfc_pkg::S_IDLE;
                  else if (prot_hit(eng_rx, addr_reg))
                     state_next = sfc_pkg::S_ABORT;
                  else
                     fr_next = sfc_pkg::FR_WREN;
               end
               sfc_pkg::FR_WREN:
               begin
                  if (op_reg == sfc_pkg::OP_ERASE)
                     fr_next = sfc_pkg::FR_SE;
                  else if (op_reg == sfc_pkg::OP_PROT)
                     fr_next = sfc_pkg::FR_WRSR;
                  else
                     fr_next = sfc_pkg::FR_PP;
               end
               sfc_pkg::FR_POLL:
               begin
                  if (!eng_rx[`SFC_SR_WIP])
                     state_next = sfc_pkg::S_IDLE;
               end
               default:
                  fr_next = sfc_pkg::FR_POLL;
            endcase
         end
         sfc_pkg::S_ABORT:
            state_next = sfc_pkg::S_IDLE;
         default:
            state_next = sfc_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         state_reg    <= sfc_pkg::S_IDLE;
         op_reg       <= sfc_pkg::OP_SID;
         fr_reg       <= sfc_pkg::FR_SID;
         idx_reg      <= 9'h000;
         in_frame_reg <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         op_reg       <= op_next;
         fr_reg       <= fr_next;
         idx_reg      <= idx_next;
         in_frame_reg <= in_frame;
      end
   end

   // Latch request operands
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         addr_reg <= 24'h000000;
         data_reg <= `SFC_RST_BYTE;
      end
      else if (accept)
      begin
         addr_reg <= addr_in;
         data_reg <= data_in;
      end
   end

   // Page byte count, emptied when the write ends
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         pcnt_reg <= 9'h000;
      else if ((fin || to_abort) && op_reg == sfc_pkg::OP_WRITE)
         pcnt_reg <= 9'h000;
      else if (buf_wr)
         pcnt_reg <= pcnt_reg + 9'h001;
   end

   // Results and abort flags
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         silicon_ident_out <= `SFC_RST_BYTE;
         status_byte_out   <= `SFC_RST_BYTE;
         ill_e_reg         <= 2'b00;
         ill_w_reg         <= 2'b00;
      end
      else
      begin
         if (fin && fr_reg == sfc_pkg::FR_SID)
            silicon_ident_out <= eng_rx;
         if (fin && fr_reg == sfc_pkg::FR_RDSR)
            status_byte_out <= eng_rx;
         ill_e_reg <= abort_e ? 2'b11 : {1'b0, ill_e_reg[1]};
         ill_w_reg <= abort_w ? 2'b11 : {1'b0, ill_w_reg[1]};
      end
   end

   // Software port: sticky events, mask, state
   wire       wr_stat = reg_wr_in && (reg_addr_in == `SFC_REG_IRQ_STAT);
   wire       wr_mask = reg_wr_in && (reg_addr_in == `SFC_REG_IRQ_MASK);
   wire [3:0] ev      = {refuse, abort_w, abort_e, fin};
   wire [3:0] w1c     = wr_stat ? reg_wdata_in[3:0] : 4'h0;
   wire [7:0] rd_word = (reg_addr_in == `SFC_REG_IRQ_STAT) ? {4'h0, irq_stat_reg} :
                        (reg_addr_in == `SFC_REG_IRQ_MASK) ? {4'h0, irq_mask_reg} :
                        (reg_addr_in == `SFC_REG_STATE)    ? {6'h00, page_mode, !idle} :
                        8'h00;

   assign irq_out = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         irq_stat_reg  <= 4'h0;
         irq_mask_reg  <= `SFC_RST_MASK;
         reg_rdata_out <= 8'h00;
      end
      else
      begin
         irq_stat_reg  <= (irq_stat_reg & ~w1c) | ev;
         reg_rdata_out <= reg_rd_in ? rd_word : 8'h00;
         if (wr_mask)
            irq_mask_reg <= reg_wdata_in[3:0];
      end
   end

   sfc_page_buf
   #(
      .WIDTH (8),
      .DEPTH (PAGE_BYTES)
   )
   u_buf
   (
      .clk_sys_in  (clk_sys_in),
      .rst_in      (rst_in),
      .wr_en_in    (buf_wr),
      .wr_addr_in  (pcnt_reg[AW-1:0]),
      .wr_data_in  (data_in),
      .rd_addr_in  (boff[AW-1:0]),
      .rd_data_out (buf_rdata)
   );

   sfc_spi_byte u_eng
   (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .start_in   (eng_start),
      .tx_in      (tx),
      .miso_in    (flash_miso_in),
      .sclk_out   (flash_sclk_out),
      .mosi_out   (flash_mosi_out),
      .rx_out     (eng_rx),
      .done_out   (eng_done)
   );

endmodule : sfc_port

// *** hw/sfc_map.svh ***
// Function
// - Identification request fetches the flash ID onto silicon_ident_out.
// - Status request reads the flash status register onto the status byte output.
// - Erase request starts erasing the sector holding the latched address.
// - Any address inside the sector selects that sector for erase.
// - Protection request writes the data byte into the flash status register.
// - While shift strobe is high and the port is idle, each clock edge stores a byte into page buffer until it is full.
// - Writes and erases start only if the write permit input is high when the request is taken.
// - Without the permit input, all writes and erases are permitted.
// - Single-byte write programs the data byte at the given address.
// - Page write programs buffered bytes from the address onward.
// - Busy is high while an instruction runs, low once it completes.
// - Erase of a protected sector aborts; illegal flag high two cycles around busy fall.
// - Identification value holds until reset or the next identification request completes; sample after busy falls.
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_OPC_WREN     8'h06
`define SFC_OPC_RDSR     8'h05
`define SFC_OPC_WRSR     8'h01
`define SFC_OPC_PP       8'h02
`define SFC_OPC_SE       8'hD8
`define SFC_OPC_SID      8'hAB
`define SFC_LEN_SID      9'h005
`define SFC_LEN_RDSR     9'h002
`define SFC_LEN_WREN     9'h001
`define SFC_LEN_SE       9'h004
`define SFC_LEN_WRSR     9'h002
`define SFC_HDR_LEN      9'h004
`define SFC_SR_WIP       0
`define SFC_SR_BP_LSB    2
`define SFC_SECTOR_LSB   16
`define SFC_REG_IRQ_STAT 4'h0
`define SFC_REG_IRQ_MASK 4'h1
`define SFC_REG_STATE    4'h2
`define SFC_EV_DONE      0
`define SFC_EV_ILL_ERASE 1
`define SFC_EV_ILL_WRITE 2
`define SFC_EV_REFUSED   3
`define SFC_RST_MASK     4'h0
`define SFC_RST_BYTE     8'h00
`endif

// *** hw/sfc_pkg.sv ***
package sfc_pkg;

   typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SEND, S_WAIT, S_GAP, S_ABORT} sfc_state_t;

   typedef enum logic [2:0] {OP_SID, OP_RDSR, OP_ERASE, OP_PROT, OP_WRITE} sfc_op_t;

   typedef enum logic [2:0] {FR_SID, FR_RDSR, FR_WREN, FR_SE, FR_WRSR, FR_PP, FR_POLL} sfc_fr_t;

endpackage : sfc_pkg

// *** hw/sfc_page_buf.sv ***
`timescale 1ns/1ns
module sfc_page_buf
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256
)
(
   input  wire logic                     clk_sys_in,
   input  wire logic                     rst_in,
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic      [WIDTH-1:0]         rd_data_out
);

   if (WIDTH < 1 || DEPTH < 2)
   begin : g_bad_size
      $error("sfc_page_buf needs WIDTH >= 1 and DEPTH >= 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];

   // Stores shifted bytes
   always_ff @(posedge clk_sys_in)
   begin
      if (wr_en_in)
      begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // Registered read port
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         rd_data_out <= '0;
      end
      else
      begin
         rd_data_out <= mem[rd_addr_in];
      end
   end

endmodule : sfc_page_buf

// *** hw/sfc_spi_byte.sv ***
`timescale 1ns/1ns
module sfc_spi_byte
(
   input  wire logic       clk_sys_in,
   input  wire logic       rst_in,
   input  wire logic       start_in,
   input  wire logic [7:0] tx_in,
   input  wire logic       miso_in,
   output logic            sclk_out,
   output logic            mosi_out,
   output logic [7:0]      rx_out,
   output logic            done_out
);

   logic       act_reg;
   logic [2:0] cnt_reg;
   logic [7:0] sh_reg;

   wire last_fall = act_reg & sclk_out & (cnt_reg == 3'h7);

   // Mode 0, one bit per two system clocks, sample on rising edge
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         act_reg  <= 1'b0;
         cnt_reg  <= 3'h0;
         sh_reg   <= 8'h00;
         sclk_out <= 1'b0;
         mosi_out <= 1'b0;
         rx_out   <= 8'h00;
         done_out <= 1'b0;
      end
      else
      begin
         done_out <= last_fall;
         if (start_in && !act_reg)
         begin
            act_reg  <= 1'b1;
            cnt_reg  <= 3'h0;
            sh_reg   <= tx_in;
            mosi_out <= tx_in[7];
         end
         else if (act_reg && !sclk_out)
         begin
            sclk_out <= 1'b1;
            rx_out   <= {rx_out[6:0], miso_in};
         end
         else if (act_reg)
         begin
            sclk_out <= 1'b0;
            act_reg  <= !last_fall;
            cnt_reg  <= cnt_reg + 3'h1;
            sh_reg   <= {sh_reg[6:0], 1'b0};
            mosi_out <= sh_reg[6];
         end
      end
   end

endmodule : sfc_spi_byte

// *** dv/sfc_port_chk.sv ***
`timescale 1ns/1ns
module sfc_port_chk
#(
   parameter bit PERMIT_PRESENT = 1'b1
)
(
   input wire logic       clk_sys_in,
   input wire logic       rst_in,
   input wire logic       sid_req_in,
   input wire logic       status_req_in,
   input wire logic       erase_req_in,
   input wire logic       protect_req_in,
   input wire logic       write_req_in,
   input wire logic       write_permit_in,
   input wire logic [7:0] silicon_ident_out,
   input wire logic [7:0] status_byte_out,
   input wire logic       busy_out,
   input wire logic       illegal_erase_out,
   input wire logic       flash_cs_n_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   sid_start_a: assert property (!busy_out && sid_req_in |=> busy_out ##[1:300] !busy_out)
      else $error("ident read did not start and finish");
   status_start_a: assert property (!busy_out && status_req_in && !sid_req_in
      |=> busy_out && !flash_cs_n_out)
      else $error("status read did not open a frame");
   permit_refuse_a: assert property (!busy_out && PERMIT_PRESENT && !write_permit_in
      && !sid_req_in && !status_req_in && (erase_req_in || protect_req_in || write_req_in)
      |=> !busy_out)
      else $error("request without permit was started");
   erase_go_a: assert property (!busy_out && write_permit_in && erase_req_in
      && !sid_req_in && !status_req_in |=> busy_out)
      else $error("permitted erase did not start");
   write_go_a: assert property (!busy_out && write_permit_in && write_req_in && !sid_req_in
      && !status_req_in && !erase_req_in && !protect_req_in |=> busy_out)
      else $error("permitted write did not start");
   ill_pulse_a: assert property ($rose(illegal_erase_out) |-> busy_out
      ##1 (illegal_erase_out && !busy_out) ##1 !illegal_erase_out)
      else $error("illegal erase pulse misplaced");
   ident_hold_a: assert property (!$stable(silicon_ident_out) |-> $fell(busy_out))
      else $error("ident output changed outside completion");
   status_hold_a: assert property (!$stable(status_byte_out) |-> $fell(busy_out))
      else $error("status output changed outside completion");
   frame_busy_a: assert property (!flash_cs_n_out |-> busy_out)
      else $error("flash frame open while not busy");
endmodule : sfc_port_chk

bind sfc_port sfc_port_chk #(.PERMIT_PRESENT(PERMIT_PRESENT)) u_chk (.clk_sys_in, .rst_in,
   .sid_req_in, .status_req_in, .erase_req_in, .protect_req_in, .write_req_in,
   .write_permit_in, .silicon_ident_out, .status_byte_out, .busy_out, .illegal_erase_out,
   .flash_cs_n_out);

// *** dv/sfc_flash_model.sv ***
`timescale 1ns/1ns
module sfc_flash_model
#(
   parameter logic [7:0] IDENT = 8'h5A // Arbitrary value
)
(
   input  wire logic sclk_in,
   input  wire logic cs_n_in,
   input  wire logic mosi_in,
   output logic      miso_out
);
   logic [7:0]  q[$];
   logic [7:0]  pp_data[$];
   logic [7:0]  sh;
   logic [7:0]  rb;
   logic [7:0]  sr = 8'h00;
   logic [7:0]  er_sector;
   logic [23:0] pp_addr;
   int          bc = 0;
   int          wip = 0;
   int          erases = 0;
   int          progs = 0;

   function automatic logic [7:0] resp(input int b);
      if (b == 0 || q.size() == 0) return 8'hC3;
      if (q[0] == 8'hAB) return (b >= 4) ? IDENT : 8'h3C;
      if (q[0] == 8'h05) return {sr[7:1], wip != 0};
      return 8'hC3;
   endfunction : resp

   initial miso_out = 1'b0;

   // Released line shows the inverse of its last value
   always @(negedge cs_n_in)
   begin
      bc = 0;
      q.delete();
      miso_out = ~miso_out;
   end

   always @(posedge sclk_in)
   begin
      if (!cs_n_in)
      begin
         sh = {sh[6:0], mosi_in};
         bc++;
         if (bc % 8 == 0) q.push_back(sh);
      end
   end

   always @(negedge sclk_in)
   begin
      if (!cs_n_in)
      begin
         rb = resp(bc / 8);
         miso_out = rb[7 - bc % 8];
      end
   end

   always @(posedge cs_n_in)
   begin
      miso_out = ~miso_out;
      if (q.size() > 1 && q[0] == 8'h01) sr = {q[1][7:2], 2'b00};
      if (q.size() >= 4 && q[0] == 8'hD8)
      begin
         erases++;
         er_sector = q[1];
         wip = 2;
      end
      if (q.size() >= 4 && q[0] == 8'h02)
      begin
         progs++;
         pp_addr = {q[1], q[2], q[3]};
         pp_data = q[4:$];
         wip = 2;
      end
      if (q.size() > 0 && q[0] == 8'h05 && wip > 0) wip--;
   end
endmodule : sfc_flash_model

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
   localparam logic [7:0] IDENT = 8'h5A; // Arbitrary value
   logic        clk_sys_in, rst_in, shift_bytes_in, write_permit_in, flash_miso_in;
   logic        reg_wr_in, reg_rd_in, busy_out, illegal_erase_out, irq_out;
   logic        flash_sclk_out, flash_cs_n_out, flash_mosi_out, illegal_write_out, busy2;
   logic [4:0]  req;
   logic [23:0] addr_in, a;
   logic [7:0]  data_in, reg_wdata_in, reg_rdata_out, silicon_ident_out, status_byte_out, d, v;
   logic [7:0]  pb[8];
   logic [3:0]  reg_addr_in;
   int          fails = 0, total_checks = 0, cycles = 0, ill_cnt = 0, illw_cnt = 0, n;

   sfc_port DUT (.clk_sys_in, .rst_in, .sid_req_in(req[0]), .status_req_in(req[1]),
      .erase_req_in(req[2]), .protect_req_in(req[3]), .write_req_in(req[4]),
      .shift_bytes_in, .write_permit_in, .addr_in, .data_in, .silicon_ident_out,
      .status_byte_out, .busy_out, .illegal_erase_out, .illegal_write_out,
      .flash_sclk_out, .flash_cs_n_out, .flash_mosi_out, .flash_miso_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out);
   sfc_flash_model #(.IDENT(IDENT)) m (.sclk_in(flash_sclk_out), .cs_n_in(flash_cs_n_out),
      .mosi_in(flash_mosi_out), .miso_out(flash_miso_in));
   // Second port built without the permit input
   sfc_port #(.PERMIT_PRESENT(1'b0)) DUT2 (.clk_sys_in, .rst_in, .sid_req_in(req[0]),
      .status_req_in(req[1]), .erase_req_in(req[2]), .protect_req_in(req[3]),
      .write_req_in(req[4]), .shift_bytes_in, .write_permit_in, .addr_in, .data_in,
      .silicon_ident_out(), .status_byte_out(), .busy_out(busy2), .illegal_erase_out(),
      .illegal_write_out(), .flash_sclk_out(), .flash_cs_n_out(), .flash_mosi_out(),
      .flash_miso_in(1'b0), .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out(), .irq_out());

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (illegal_erase_out === 1'b1) ill_cnt++;
      if (illegal_write_out === 1'b1) illw_cnt++;
      if (cycles == 20000)
      begin
         fails++;
         conclude();
      end
   end

   // Permit is driven with every request; optional mid-run erase while busy
   task automatic run(input int k, input logic [23:0] ad, input logic [7:0] dd,
                      input logic p, input logic spur);
      int w;
      @(posedge clk_sys_in);
      req[k] <= 1'b1;
      addr_in <= ad;
      data_in <= dd;
      write_permit_in <= p;
      @(posedge clk_sys_in);
      req <= 5'h00;
      #1;
      w = 0;
      while (busy_out !== 1'b0 && w < 3000)
      begin
         @(posedge clk_sys_in);
         if (spur) req[2] <= (w == 10);
         w++;
         #1;
      end
      chk("busy falls", w < 3000, 1);
   endtask : run

   task automatic reg_wr(input logic [3:0] ra, input logic [7:0] rd);
      @(posedge clk_sys_in);
      reg_addr_in <= ra;
      reg_wdata_in <= rd;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] ra, output logic [7:0] rd);
      @(posedge clk_sys_in);
      reg_addr_in <= ra;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1;
      rd = reg_rdata_out;
   endtask : reg_rd

   initial
   begin
      rst_in = 1'b1;
      req = 5'h00;
      {shift_bytes_in, write_permit_in, reg_wr_in, reg_rd_in} = 4'h0;
      {addr_in, data_in, reg_wdata_in, reg_addr_in} = 44'h0;
      void'($urandom(25251));
      repeat (5) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      chk("cs idle", flash_cs_n_out, 1);
      reg_rd(4'h1, v);
      chk("mask reset", v, 8'h00);
      run(0, 24'h0, 8'h00, 1'b1, 1'b1);
      chk("ident", silicon_ident_out, IDENT);
      chk("erase while busy", m.erases, 0);
      d = {3'($urandom), 3'h1, 2'($urandom)};
      run(3, 24'h0, d, 1'b1, 1'b0);
      run(1, 24'h0, 8'h00, 1'b1, 1'b0);
      chk("status", status_byte_out, {d[7:2], 2'b00});
      chk("ident held", silicon_ident_out, IDENT);
      a = {8'($urandom_range(30, 0)), 16'($urandom)};
      run(2, a, 8'h00, 1'b1, 1'b0);
      chk("erase count", m.erases, 1);
      chk("erase sector", m.er_sector, a[23:16]);
      n = ill_cnt;
      run(2, {8'h1F, 16'($urandom)}, 8'h00, 1'b1, 1'b0);
      @(posedge clk_sys_in);
      #1;
      chk("protected erase", m.erases, 1);
      chk("illegal cycles", ill_cnt - n, 2);
      reg_wr(4'h0, 8'h0F);
      wait (busy2 === 1'b0);
      run(2, a, 8'h00, 1'b0, 1'b0);
      chk("refused erase", m.erases, 1);
      chk("permit absent", busy2, 1);
      reg_rd(4'h0, v);
      chk("refused event", v, 8'h08);
      chk("irq masked", irq_out, 0);
      reg_wr(4'h1, 8'h08);
      chk("irq raised", irq_out, 1);
      reg_wr(4'h0, 8'h08);
      chk("irq cleared", irq_out, 0);
      reg_rd(4'hF, v);
      chk("unmapped", v, 8'h00);
      // Page bytes are shifted in before the write request
      n = $urandom_range(6, 2);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_sys_in);
         pb[i] = 8'($urandom);
         shift_bytes_in <= 1'b1;
         data_in <= pb[i];
      end
      @(posedge clk_sys_in);
      shift_bytes_in <= 1'b0;
      reg_rd(4'h2, v);
      chk("page pending", v, 8'h02);
      run(4, a, 8'h00, 1'b1, 1'b0);
      chk("page addr", m.pp_addr, a);
      chk("page size", m.pp_data.size(), n);
      for (int i = 0; i < n; i++) chk("page byte", m.pp_data[i], pb[i]);
      d = 8'($urandom);
      run(4, a ^ 24'h000100, d, 1'b1, 1'b0);
      chk("single count", m.pp_data.size(), 1);
      chk("single byte", m.pp_data[0], d);
      run(4, {8'h1F, 16'($urandom)}, d, 1'b1, 1'b0);
      @(posedge clk_sys_in);
      #1;
      chk("protected write", m.progs, 2);
      chk("illegal write cycles", illw_cnt, 2);
      conclude();
   end
endmodule : tb_top
